// *** logic/csi_fault_detect.sv ***
// Purpose: Combinational detection of arithmetic fault events.
// Assumes: Results arrive sign-extended by one bit beyond their precision.
// Notes: Outputs are one-cycle events; latching happens in csi_top.
`timescale 1ns/100ps
module csi_fault_detect
    import csi_pkg::*;
(
    // Arithmetic events
    input wire csi_arith_t arith,
    // Detected events
    output logic ovf_evt,
    output logic div_evt,
    output logic exp_evt
);

    // True when a value does not fit its precision, sign included.
    function automatic logic csi_no_fit(input logic [DP_BITS:0] v, input logic dp);
        logic fit;
        fit = 1'b0;
        if (dp) begin
            fit = (v[DP_BITS] == v[DP_BITS-1]);
        end else begin
            fit = (v[DP_BITS:SP_BITS-1] == {(DP_BITS-SP_BITS+2){v[SP_BITS-1]}});
        end
        return !fit;
    endfunction

    logic div_small;
    always_comb begin
        div_small = (arith.divisor_mag == '0);
    end

    always_comb begin
        ovf_evt = arith.add_valid && csi_no_fit(arith.add_result, arith.double_prec);
        div_evt = 1'b0;
        if (arith.div_valid) begin
            if (arith.float_div) begin
                // Unnormalized divisors are faulted too; that case is not allowed.
                div_evt = div_small || !arith.divisor_float_ok || !arith.divisor_normalized;
            end else begin
                div_evt = div_small || csi_no_fit(arith.quotient, arith.double_prec);
            end
        end
        exp_evt = arith.exp_valid && (arith.exp_mag > {1'b0, EXP_LIMIT});
    end

endmodule

// *** logic/csi_pkg.sv ***
// Purpose: Shared types and constants for the computer status indicator logic.
// Assumes: One 100 MHz processor clock; all inputs synchronous to it.
// Notes: Register map is for the APB slave inside csi_top.
package csi_pkg;

    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned SP_BITS = 24;
    localparam int unsigned DP_BITS = 48;
    localparam int unsigned EXP_BITS = 12;
    // Largest exponent magnitude, 1777 octal.
    localparam logic [EXP_BITS-1:0] EXP_LIMIT = 12'h3FF;

    // APB register byte addresses.
    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [11:0] ADDR_FAULT = 12'h004;
    localparam logic [11:0] ADDR_CLEAR = 12'h008;
    localparam logic [11:0] ADDR_LAMP_EN = 12'h00C;

    // Fault vector bit positions.
    localparam int unsigned F_OVF = 0;
    localparam int unsigned F_DIV = 1;
    localparam int unsigned F_EXP = 2;
    localparam int unsigned F_DEC = 3;
    localparam int unsigned F_ILW = 4;
    localparam int unsigned F_STO = 5;
    localparam int unsigned F_ADP = 6;
    localparam int unsigned NUM_FAULTS = 7;

    localparam logic [NUM_FAULTS-1:0] FAULT_RST = 7'h00;
    localparam logic LAMP_EN_RST = 1'b1;
    localparam logic [11:0] DECIMAL_FAULT_OPCODE = 12'hFFA;

    typedef enum logic [2:0] {
        CYC_IDLE,
        CYC_FETCH,
        CYC_INDIRECT,
        CYC_OP_READ,
        CYC_OP_WRITE
    } csi_cycle_t;

    // Storage side events from the processor.
    typedef struct packed {
        logic [3:0] module_busy;
        logic addr_parity_err;
        logic data_parity_err;
        logic no_response;
        logic realtime_intr_processor_parity;
        logic io_channel_parity;
        logic protect_write;
    } csi_storage_t;

    // Arithmetic side events.
    typedef struct packed {
        logic add_valid;
        logic double_prec;
        logic [DP_BITS:0] add_result;
        logic div_valid;
        logic float_div;
        logic [DP_BITS:0] quotient;
        logic [DP_BITS-1:0] divisor_mag;
        logic divisor_float_ok;
        logic divisor_normalized;
        logic exp_valid;
        logic exp_neg;
        logic [EXP_BITS:0] exp_mag;
        logic business_proc_section_fault;
        logic instr_done;
        logic [11:0] instr_code;
    } csi_arith_t;

    typedef struct packed {
        logic storage_busy;
        logic supervisor_state;
        logic user_state;
        logic intr_enabled;
        logic instr_fetch_cycle;
        logic indirect_addr_cycle;
        logic operand_read_cycle;
        logic operand_write_cycle;
        logic maint_active;
    } csi_lamps_t;

endpackage

// *** logic/csi_top.sv ***
// Purpose: Drives the operator status lamps from processor state and faults.
// Assumes: Inputs synchronous to sys_clk; fault clearing arrives as a pulse.
// Notes: Faults are also readable and clearable over APB.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/100ps

module csi_top
    import csi_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Processor state
    input wire csi_cycle_t cycle,
    input wire logic exec_supervisor,
    input wire logic exec_user,
    input wire logic intr_sys_enabled,
    input wire logic maint_key_on,
    input wire logic fault_clear,
    input wire csi_storage_t storage,
    input wire csi_arith_t arith,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Console lamps
    output csi_lamps_t lamps,
    output logic [NUM_FAULTS-1:0] fault_lamps
);

    csi_lamps_t lamps_d;
    logic [NUM_FAULTS-1:0] fault_q;
    logic [NUM_FAULTS-1:0] fault_set;
    logic [NUM_FAULTS-1:0] sw_clear;
    logic lamp_en_q;
    logic ovf_evt;
    logic div_evt;
    logic exp_evt;
    logic apb_access;
    logic apb_write;
    logic addr_ok;

    // Register write decode, shared by the clear strobe and the lamp enable.
    function automatic logic csi_reg_write(input logic wr, input logic [11:0] a, input logic [11:0] target);
        return wr && (a == target);
    endfunction

    csi_fault_detect u_detect (
        .arith(arith),
        .ovf_evt(ovf_evt),
        .div_evt(div_evt),
        .exp_evt(exp_evt)
    );

    always_comb begin
        lamps_d = '0;
        lamps_d.storage_busy = |storage.module_busy;
        lamps_d.supervisor_state = exec_supervisor;
        lamps_d.user_state = exec_user && !exec_supervisor;
        lamps_d.intr_enabled = intr_sys_enabled;
        lamps_d.maint_active = maint_key_on;
        // A single enum input makes overlapping cycle lamps impossible.
        unique case (cycle)
            CYC_IDLE: begin
            end
            CYC_FETCH: begin
                lamps_d.instr_fetch_cycle = 1'b1;
            end
            CYC_INDIRECT: begin
                lamps_d.indirect_addr_cycle = 1'b1;
            end
            CYC_OP_READ: begin
                lamps_d.operand_read_cycle = 1'b1;
            end
            CYC_OP_WRITE: begin
                lamps_d.operand_write_cycle = 1'b1;
            end
            default: begin
            end
        endcase
        if (!lamp_en_q) begin
            lamps_d = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            lamps <= '0;
        end else begin
            lamps <= lamps_d;
        end
    end

    always_comb begin
        fault_set = '0;
        fault_set[F_OVF] = ovf_evt;
        fault_set[F_DIV] = div_evt;
        fault_set[F_EXP] = exp_evt;
        fault_set[F_DEC] = arith.business_proc_section_fault ||
            (arith.instr_done && arith.instr_code == DECIMAL_FAULT_OPCODE);
        fault_set[F_ILW] = storage.protect_write;
        // Channel parity is deliberately not an input to this term.
        fault_set[F_STO] = storage.addr_parity_err || storage.data_parity_err ||
            storage.no_response || storage.realtime_intr_processor_parity;
        fault_set[F_ADP] = storage.addr_parity_err;
    end

    assign apb_access = psel && penable;
    assign apb_write = apb_access && pwrite;
    assign addr_ok = (paddr == ADDR_STATUS) || (paddr == ADDR_FAULT) ||
        (paddr == ADDR_CLEAR) || (paddr == ADDR_LAMP_EN);

    always_comb begin
        sw_clear = '0;
        if (csi_reg_write(apb_write, paddr, ADDR_CLEAR)) begin
            sw_clear = pwdata[NUM_FAULTS-1:0];
        end
    end

    // Set wins over clear so a fault in the clearing cycle is not lost.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_q <= FAULT_RST;
        end else begin
            fault_q <= ((fault_clear ? '0 : fault_q) & ~sw_clear) | fault_set;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_lamps <= FAULT_RST;
        end else begin
            fault_lamps <= lamp_en_q ? fault_q : FAULT_RST;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            lamp_en_q <= LAMP_EN_RST;
        end else if (csi_reg_write(apb_write, paddr, ADDR_LAMP_EN)) begin
            lamp_en_q <= pwdata[0];
        end
    end

    // APB: zero wait states; unmapped addresses answer with pslverr.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata <= '0;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    ADDR_STATUS: prdata <= {23'h0, lamps_d};
                    ADDR_FAULT: prdata <= {25'h0, fault_q};
                    ADDR_LAMP_EN: prdata <= {31'h0, lamp_en_q};
                    default: prdata <= '0;
                endcase
            end
        end
    end

    // Cycle lamps.
    chk_cycle_onehot: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $onehot0({lamps.instr_fetch_cycle, lamps.indirect_addr_cycle,
                  lamps.operand_read_cycle, lamps.operand_write_cycle}))
        else $error("more than one cycle lamp lit");

    chk_fetch_lamp: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cycle == CYC_FETCH && lamp_en_q) |=> lamps.instr_fetch_cycle)
        else $error("fetch lamp missed");

    chk_indirect_lamp: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cycle == CYC_INDIRECT && lamp_en_q) |=> lamps.indirect_addr_cycle)
        else $error("indirect lamp missed");

    chk_read_lamp: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cycle == CYC_OP_READ && lamp_en_q) |=> lamps.operand_read_cycle)
        else $error("operand read lamp missed");

    chk_store_lamp: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cycle == CYC_OP_WRITE && lamp_en_q) |=> lamps.operand_write_cycle)
        else $error("store lamp missed");

    // State lamps, then lamps dark when disabled and fault lamp copy.
    chk_busy_follows: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (|storage.module_busy && lamp_en_q) |=> lamps.storage_busy)
        else $error("storage busy lamp missed");

    chk_super_lamp: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (exec_supervisor && lamp_en_q) |=> lamps.supervisor_state)
        else $error("supervisor lamp missed");

    chk_user_lamp: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (exec_user && !exec_supervisor && lamp_en_q) |=> lamps.user_state)
        else $error("user lamp missed");

    chk_user_masked: assert property (@(posedge sys_clk) disable iff (!arst_n)
        exec_supervisor |=> !lamps.user_state)
        else $error("user lamp lit in supervisor state");

    chk_intr_lamp: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (intr_sys_enabled && lamp_en_q) |=> lamps.intr_enabled)
        else $error("interrupt lamp missed");

    chk_maint_lamp: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (maint_key_on && lamp_en_q) |=> lamps.maint_active)
        else $error("maintenance lamp missed");

    chk_lamps_dark: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !lamp_en_q |=> (lamps == '0 && fault_lamps == '0))
        else $error("lamp lit while lamps disabled");

    chk_fault_copy: assert property (@(posedge sys_clk) disable iff (!arst_n)
        lamp_en_q |=> (fault_lamps == $past(fault_q)))
        else $error("fault lamps do not follow fault flags");

    // Arithmetic faults. Most expectations use the raw inputs, not the detector outputs,
    // so that a broken detector is caught here as well.
    chk_overflow: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ovf_evt |=> fault_q[F_OVF])
        else $error("overflow not latched");

    chk_overflow_single: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (arith.add_valid && !arith.double_prec &&
            arith.add_result[SP_BITS] != arith.add_result[SP_BITS-1]) |=> fault_q[F_OVF])
        else $error("single precision overflow missed");

    chk_overflow_double: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (arith.add_valid && arith.double_prec &&
            arith.add_result[DP_BITS] != arith.add_result[DP_BITS-1]) |=> fault_q[F_OVF])
        else $error("double precision overflow missed");

    chk_quotient_wide: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (arith.div_valid && !arith.float_div && !arith.double_prec &&
            arith.quotient[SP_BITS] != arith.quotient[SP_BITS-1]) |=> fault_q[F_DIV])
        else $error("wide quotient not faulted");

    chk_zero_divisor: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (arith.div_valid && arith.divisor_mag == '0) |=> fault_q[F_DIV])
        else $error("zero divisor not faulted");

    chk_float_divisor: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (arith.div_valid && arith.float_div && !arith.divisor_float_ok) |=> fault_q[F_DIV])
        else $error("bad float divisor not faulted");

    chk_unnormalized_divisor: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (arith.div_valid && arith.float_div && !arith.divisor_normalized) |=> fault_q[F_DIV])
        else $error("unnormalized divisor not faulted");

    chk_exp_fault: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (arith.exp_valid && arith.exp_mag > {1'b0, EXP_LIMIT}) |=> fault_q[F_EXP])
        else $error("exponent fault not latched");

    chk_decimal: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (arith.instr_done && arith.instr_code == DECIMAL_FAULT_OPCODE) |=> fault_q[F_DEC])
        else $error("decimal fault not set");

    chk_section_decimal: assert property (@(posedge sys_clk) disable iff (!arst_n)
        arith.business_proc_section_fault |=> fault_q[F_DEC])
        else $error("section decimal fault not set");

    // Storage faults, then fault hold and fault clear.
    chk_illegal_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        storage.protect_write |=> fault_q[F_ILW])
        else $error("illegal write not latched");

    chk_storage_err: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (storage.no_response || storage.data_parity_err) |=> fault_q[F_STO])
        else $error("storage error flag not set");

    chk_intr_proc_parity: assert property (@(posedge sys_clk) disable iff (!arst_n)
        storage.realtime_intr_processor_parity |=> fault_q[F_STO])
        else $error("interrupt processor parity not latched");

    chk_chan_parity: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (storage.io_channel_parity && !fault_set[F_STO] && !fault_q[F_STO]) |=> !fault_q[F_STO])
        else $error("channel parity set storage flag");

    // The lamp enable is taken one cycle back, as that is the value the fault lamps were loaded with.
    chk_addr_marker: assert property (@(posedge sys_clk) disable iff (!arst_n)
        storage.addr_parity_err |=> (fault_q[F_ADP] && fault_q[F_STO]) ##1
            (fault_lamps[F_ADP] || !$past(lamp_en_q)))
        else $error("address parity marker not lit");

    chk_marker_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!storage.addr_parity_err && !fault_q[F_ADP]) |=> !fault_q[F_ADP])
        else $error("address marker lit without address parity");

    chk_fault_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (fault_q[F_DIV] && !fault_clear && !sw_clear[F_DIV]) |=> fault_q[F_DIV])
        else $error("divide fault dropped");

    chk_clear_all: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (fault_clear && fault_set == '0) |=> (fault_q == '0))
        else $error("fault flags not cleared");

endmodule

// *** test/csi_lamp_panel.sv ***
// Purpose: Behavioural model of the operator console lamp panel.
// Assumes: Lamp drive is synchronous to sys_clk; a high level lights a lamp.
// Notes: Lamps glow from the edge after drive; lamp response time is not modelled.
`timescale 1ns/100ps
module csi_lamp_panel
    import csi_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Lamp drive
    input wire csi_lamps_t lamps,
    input wire logic [NUM_FAULTS-1:0] fault_lamps,
    // Glowing lamps
    output logic [15:0] lit
);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            lit <= 16'h0000;
        end else begin
            lit <= {lamps, fault_lamps};
        end
    end
endmodule

// *** test/testbench.sv ***
// Purpose: Self-checking bench for the status indicator logic.
// Assumes: Zero-wait APB slave; lamps one cycle and fault lamps two cycles after inputs.
// Notes: Every fault case is cleared before the next so each starts clean.
`timescale 1ns/100ps
module testbench
    import csi_pkg::*;
;
    logic sys_clk, arst_n, exec_supervisor, exec_user, intr_sys_enabled, maint_key_on, fault_clear;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    csi_cycle_t cycle;
    csi_storage_t storage;
    csi_arith_t arith;
    csi_lamps_t lamps;
    logic [NUM_FAULTS-1:0] fault_lamps;
    logic [15:0] panel_lit;
    int n_fail, num_checks;
    csi_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .cycle(cycle), .exec_supervisor(exec_supervisor),
        .exec_user(exec_user), .intr_sys_enabled(intr_sys_enabled), .maint_key_on(maint_key_on),
        .fault_clear(fault_clear), .storage(storage), .arith(arith), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lamps(lamps), .fault_lamps(fault_lamps));
    csi_lamp_panel panel (.sys_clk(sys_clk), .arst_n(arst_n), .lamps(lamps), .fault_lamps(fault_lamps),
        .lit(panel_lit));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] d,
        output logic err);
        int i;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1) begin
            chk("pready", 32'h1, {31'h0, pready});
            results();
        end
        d = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic apb_chk(input string what, input logic [11:0] a, input logic [31:0] exp, input logic ee);
        logic [31:0] d;
        logic e;
        apb(1'b0, a, 32'h0, d, e);
        chk(what, exp, d);
        chk("pslverr", {31'h0, ee}, {31'h0, e});
    endtask
    task automatic t_state();
        logic [31:0] d;
        logic e;
        @(posedge sys_clk);
        storage.module_busy <= 4'h8;
        exec_supervisor <= 1'b1;
        intr_sys_enabled <= 1'b1;
        maint_key_on <= 1'b1;
        cycle <= CYC_FETCH;
        settle(3);
        chk("lamps", 32'h1B1, {23'h0, lamps});
        chk("panel", 32'hD880, {16'h0, panel_lit});
        apb_chk("status", ADDR_STATUS, 32'h1B1, 1'b0);
        for (int i = 1; i < 5; i++) begin
            @(posedge sys_clk);
            cycle <= csi_cycle_t'(i);
            settle(2);
            chk("cycle lamps", 32'h8 >> (i - 1), {28'h0, lamps[4:1]});
        end
        @(posedge sys_clk);
        storage.module_busy <= 4'h0;
        exec_supervisor <= 1'b0;
        exec_user <= 1'b1;
        intr_sys_enabled <= 1'b0;
        maint_key_on <= 1'b0;
        cycle <= CYC_IDLE;
        settle(2);
        chk("lamps", 32'h040, {23'h0, lamps});
        apb(1'b1, ADDR_LAMP_EN, 32'h0, d, e);
        settle(2);
        chk("lamps off", 32'h0, {23'h0, lamps});
        apb(1'b1, ADDR_LAMP_EN, 32'h1, d, e);
        exec_user <= 1'b0;
    endtask
    task automatic fcase(input csi_storage_t s, input csi_arith_t a, input logic [6:0] exp);
        @(posedge sys_clk);
        storage <= s;
        arith <= a;
        @(posedge sys_clk);
        storage <= '0;
        arith <= '0;
        settle(3);
        chk("fault lamps", {25'h0, exp}, {25'h0, fault_lamps});
        apb_chk("fault reg", ADDR_FAULT, {25'h0, exp}, 1'b0);
        @(posedge sys_clk);
        fault_clear <= 1'b1;
        @(posedge sys_clk);
        fault_clear <= 1'b0;
        settle(3);
        chk("cleared", 32'h0, {25'h0, fault_lamps});
    endtask
    task automatic t_faults();
        csi_arith_t a;
        a = '0;
        a.add_valid = 1'b1;
        a.add_result = 49'h800000;
        fcase('0, a, 7'h01);
        a.add_result = 49'h7FFFFF;
        fcase('0, a, 7'h00);
        a.double_prec = 1'b1;
        a.add_result = 49'h0_8000_0000_0000;
        fcase('0, a, 7'h01);
        a = '0;
        a.div_valid = 1'b1;
        a.divisor_mag = 48'h1;
        a.quotient = 49'h800000;
        fcase('0, a, 7'h02);
        a.quotient = 49'h1;
        a.divisor_mag = 48'h0;
        fcase('0, a, 7'h02);
        a.divisor_mag = 48'h5;
        a.float_div = 1'b1;
        a.divisor_normalized = 1'b1;
        fcase('0, a, 7'h02);
        a.divisor_float_ok = 1'b1;
        a.divisor_normalized = 1'b0;
        fcase('0, a, 7'h02);
        a = '0;
        a.exp_valid = 1'b1;
        a.exp_neg = 1'b1;
        a.exp_mag = 13'h400;
        fcase('0, a, 7'h04);
        a.exp_mag = 13'h3FF;
        fcase('0, a, 7'h00);
        a = '0;
        a.business_proc_section_fault = 1'b1;
        fcase('0, a, 7'h08);
        a = '0;
        a.instr_done = 1'b1;
        a.instr_code = DECIMAL_FAULT_OPCODE;
        fcase('0, a, 7'h08);
        a = '0;
        fcase(10'h001, a, 7'h10);
        fcase(10'h020, a, 7'h60);
        fcase(10'h010, a, 7'h20);
        fcase(10'h008, a, 7'h20);
        fcase(10'h004, a, 7'h20);
        fcase(10'h002, a, 7'h00);
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic e;
        apb_chk("lamp en", ADDR_LAMP_EN, 32'h1, 1'b0);
        @(posedge sys_clk);
        storage <= 10'h010;
        @(posedge sys_clk);
        storage <= '0;
        apb(1'b1, ADDR_CLEAR, 32'h0, d, e);
        apb_chk("fault held", ADDR_FAULT, 32'h20, 1'b0);
        apb(1'b1, ADDR_CLEAR, 32'h20, d, e);
        apb_chk("fault", ADDR_FAULT, 32'h0, 1'b0);
        apb_chk("clear", ADDR_CLEAR, 32'h0, 1'b0);
        apb(1'b1, 12'h010, 32'hFFFFFFFF, d, e);
        chk("wr slverr", 32'h1, {31'h0, e});
        apb_chk("unmapped", 12'h010, 32'h0, 1'b1);
        @(posedge sys_clk);
        storage <= 10'h020;
        @(posedge sys_clk);
        storage <= '0;
        settle(3);
        chk("pre-reset faults", 32'h60, {25'h0, fault_lamps});
        apb(1'b1, ADDR_LAMP_EN, 32'h0, d, e);
        arst_n <= 1'b0;
        settle(1);
        chk("reset faults", 32'h0, {25'h0, fault_lamps});
        @(posedge sys_clk);
        arst_n <= 1'b1;
        apb_chk("lamp en reset", ADDR_LAMP_EN, 32'h1, 1'b0);
        apb_chk("fault reset", ADDR_FAULT, 32'h0, 1'b0);
    endtask
    initial begin
        arst_n = 1'b0;
        {exec_supervisor, exec_user, intr_sys_enabled, maint_key_on, fault_clear} = 5'h00;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cycle = CYC_IDLE;
        storage = '0;
        arith = '0;
        n_fail = 0;
        num_checks = 0;
        settle(19);
        chk("reset lamps", 32'h0, {16'h0, lamps, fault_lamps});
        @(posedge sys_clk);
        arst_n <= 1'b1;
        t_state();
        t_faults();
        t_regs();
        settle(2);
        results();
    end
endmodule
